// ### verilog/flash_host_pkg.sv
// Function
// - Host writes three unlock bytes before loading
// - Host strobes write low, select low, gate high
// - Host next fall within 150 us of rise
// - Host keeps same sector address during load
// - Host waits 20 ms after power valid
package flash_host_pkg;
  localparam int CLK_MHZ = 20;
  localparam int LOAD_GAP_US = 150;
  localparam int LOAD_GAP_CYC = LOAD_GAP_US * CLK_MHZ;
  localparam int LOAD_SAFE_CYC = LOAD_GAP_CYC / 2;
  localparam int POWERUP_MS = 20;
  localparam int POWERUP_CYC = POWERUP_MS * 1000 * CLK_MHZ;
  localparam int CYCLE_MS = 20;
  localparam int CYCLE_CYC = CYCLE_MS * 1000 * CLK_MHZ;
  localparam int STROBE_NS = 200;
  localparam int CLK_NS = 50;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SECTOR_BYTES = 128;
  localparam logic [15:0] UNLOCK_ADDR0 = 16'h5555;
  localparam logic [15:0] UNLOCK_ADDR1 = 16'h2AAA;
  localparam logic [7:0] UNLOCK_DATA0 = 8'hAA;
  localparam logic [7:0] UNLOCK_DATA1 = 8'h55;
  localparam logic [7:0] UNLOCK_DATA2 = 8'hA0;
  localparam logic [6:0] OFFSET_LAST = 7'h7F;
  typedef struct packed {
    logic chipSelN;
    logic outGateN;
    logic writeStrobeN;
    logic [15:0] addr;
  } pin_ctl_t;
endpackage

// ### verilog/flash_host.sv
`timescale 1ns/10ps
module flash_host #(
  parameter int POWERUP_CYCLES = flash_host_pkg::POWERUP_CYC,
  parameter int CYCLE_CYCLES = flash_host_pkg::CYCLE_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic readReq,
  input wire logic [15:0] readAddr,
  input wire logic progReq,
  input wire logic [8:0] progSector,
  output logic loadReady,
  input wire logic loadValid,
  input wire logic [6:0] loadOffset,
  input wire logic [7:0] loadData,
  input wire logic loadLast,
  output logic busy,
  output logic readValid,
  output logic [7:0] readData,
  output logic timeoutErr,
  output flash_host_pkg::pin_ctl_t pins,
  output logic [7:0] dataOut,
  output logic dataOe,
  input wire logic [7:0] dataIn
);
  typedef enum {S_POWER, S_IDLE, S_RD, S_UNLOCK, S_LOAD, S_GAP, S_POLL, S_POLLRD} state_t;
  state_t state;
  logic [31:0] timer;
  logic [3:0] phase;
  logic [1:0] unlockIdx;
  logic [8:0] sector;
  logic [15:0] lastAddr;
  logic [7:0] lastData;
  logic [31:0] pollTimer;
  logic done;

  function automatic logic [15:0] unlock_addr(input logic [1:0] idx);
    unlock_addr = (idx == 2'd1) ? flash_host_pkg::UNLOCK_ADDR1 : flash_host_pkg::UNLOCK_ADDR0;
  endfunction
  function automatic logic [7:0] unlock_data(input logic [1:0] idx);
    if (idx == 2'd0) begin
      unlock_data = flash_host_pkg::UNLOCK_DATA0;
    end else if (idx == 2'd1) begin
      unlock_data = flash_host_pkg::UNLOCK_DATA1;
    end else begin
      unlock_data = flash_host_pkg::UNLOCK_DATA2;
    end
  endfunction

  assign busy = (state != S_IDLE);
  assign loadReady = (state == S_GAP) && (timer < flash_host_pkg::LOAD_SAFE_CYC);
  assign done = (phase == 4'(flash_host_pkg::STROBE_CYC + 1));

  // Main sequencer; strobes held 200 ns so no glitch filtering can eat them
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= S_POWER;
      timer <= '0;
      phase <= '0;
      unlockIdx <= '0;
      sector <= '0;
      lastAddr <= '0;
      lastData <= '0;
      pollTimer <= '0;
      timeoutErr <= 1'b0;
    end else begin
      case (state)
        S_POWER: begin
          timer <= timer + 32'd1;
          if (timer >= 32'(POWERUP_CYCLES)) begin
            state <= S_IDLE;
          end
        end
        S_IDLE: begin
          phase <= '0;
          if (progReq) begin
            sector <= progSector;
            unlockIdx <= '0;
            timeoutErr <= 1'b0;
            state <= S_UNLOCK;
          end else if (readReq) begin
            state <= S_RD;
          end
        end
        S_RD: begin
          phase <= phase + 4'd1;
          if (done) begin
            state <= S_IDLE;
          end
        end
        S_UNLOCK: begin
          phase <= phase + 4'd1;
          if (done) begin
            phase <= '0;
            unlockIdx <= unlockIdx + 2'd1;
            if (unlockIdx == 2'd2) begin
              timer <= '0;
              state <= S_GAP;
            end
          end
        end
        S_GAP: begin
          timer <= timer + 32'd1;
          if (loadValid && loadReady) begin
            lastAddr <= {sector, loadOffset};
            lastData <= loadData;
            phase <= '0;
            state <= S_LOAD;
          end else if (timer >= 32'(flash_host_pkg::LOAD_SAFE_CYC)) begin
            pollTimer <= '0; // Source stalled: device closes load itself
            phase <= '0;
            state <= S_POLLRD;
          end
        end
        S_LOAD: begin
          phase <= phase + 4'd1;
          if (done) begin
            timer <= '0;
            state <= S_GAP;
          end
        end
        S_POLLRD: begin
          phase <= phase + 4'd1;
          pollTimer <= pollTimer + 32'd1;
          if (done) begin
            phase <= '0;
            if (dataIn[7] == lastData[7]) begin
              state <= S_IDLE;
            end else if (pollTimer >= 32'(CYCLE_CYCLES)) begin
              timeoutErr <= 1'b1;
              state <= S_IDLE;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Pin drive: write cycles keep gate high, reads keep write strobe high
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pins <= '{chipSelN: 1'b1, outGateN: 1'b1, writeStrobeN: 1'b1, addr: 16'h0000};
      dataOut <= '0;
      dataOe <= 1'b0;
    end else begin
      pins.chipSelN <= 1'b1;
      pins.outGateN <= 1'b1;
      pins.writeStrobeN <= 1'b1;
      dataOe <= 1'b0;
      // Select held one cycle past the write rise so the data edge sees it low
      if (state == S_UNLOCK || state == S_LOAD) begin
        pins.addr <= (state == S_UNLOCK) ? unlock_addr(unlockIdx) : lastAddr;
        dataOut <= (state == S_UNLOCK) ? unlock_data(unlockIdx) : lastData;
        dataOe <= 1'b1;
        pins.chipSelN <= 1'b0;
        pins.writeStrobeN <= (phase == 4'd0) || (phase > 4'(flash_host_pkg::STROBE_CYC));
      end else if ((state == S_RD || state == S_POLLRD) && !done) begin
        pins.addr <= (state == S_RD) ? readAddr : lastAddr;
        pins.chipSelN <= 1'b0;
        pins.outGateN <= (phase == 4'd0);
      end
    end
  end

  // Sample read data at end of access time
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      readValid <= 1'b0;
      readData <= '0;
    end else begin
      readValid <= 1'b0;
      if ((state == S_RD || state == S_POLLRD) && phase == 4'(flash_host_pkg::STROBE_CYC)) begin
        readData <= dataIn;
        readValid <= (state == S_RD);
      end
    end
  end

  // Counts write-low cycles so the pulse width is checked on release
  logic [3:0] lowCount;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lowCount <= '0;
    end else if (!pins.writeStrobeN) begin
      lowCount <= lowCount + 4'd1;
    end else begin
      lowCount <= '0;
    end
  end

  a_pulse_full_width: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(pins.writeStrobeN) |-> lowCount >= 4'(flash_host_pkg::STROBE_CYC)) else $error("write pulse short");
  a_write_bus_stable: assert property (@(posedge clk_sys) disable iff (srst)
    !pins.writeStrobeN |-> $stable(dataOut) && $stable(pins.addr)) else $error("bus moved under strobe");
  a_unlock_addr: assert property (@(posedge clk_sys) disable iff (srst)
    state == S_UNLOCK && !pins.writeStrobeN |-> pins.addr == unlock_addr(unlockIdx)) else $error("bad unlock address");
  a_gap_closed: assert property (@(posedge clk_sys) disable iff (srst)
    state == S_GAP && timer >= 32'(flash_host_pkg::LOAD_SAFE_CYC) |-> !loadReady) else $error("late load offered");
  a_power_quiet: assert property (@(posedge clk_sys) disable iff (srst)
    state == S_POWER |-> !dataOe && pins.writeStrobeN) else $error("drive during power wait");
  a_load_sector: assert property (@(posedge clk_sys) disable iff (srst)
    state == S_LOAD |-> lastAddr[15:7] == sector) else $error("load outside sector");
  a_gate_write_excl: assert property (@(posedge clk_sys) disable iff (srst)
    !(!pins.outGateN && !pins.writeStrobeN)) else $error("gate and write strobe both low");
  a_drive_gate_excl: assert property (@(posedge clk_sys) disable iff (srst)
    !(dataOe && !pins.outGateN)) else $error("host drives data while gate low");
  a_strobe_width: assert property (@(posedge clk_sys) disable iff (srst)
    $fell(pins.writeStrobeN) |-> !pins.writeStrobeN [*4]) else $error("write strobe too short");
  a_strobe_cs_low: assert property (@(posedge clk_sys) disable iff (srst)
    !pins.writeStrobeN |-> !pins.chipSelN && dataOe) else $error("strobe without select");
  a_gap_bound: assert property (@(posedge clk_sys) disable iff (srst)
    state == S_GAP |-> timer <= 32'(flash_host_pkg::LOAD_SAFE_CYC)) else $error("load gap overrun");
  a_sector_hold: assert property (@(posedge clk_sys) disable iff (srst)
    $fell(pins.writeStrobeN) && state == S_LOAD |-> pins.addr[15:7] == sector) else $error("sector changed");
  a_unlock_first: assert property (@(posedge clk_sys) disable iff (srst)
    state == S_IDLE && progReq |=> state == S_UNLOCK) else $error("unlock skipped");
  a_busy_poll: assert property (@(posedge clk_sys) disable iff (srst)
    state == S_POLLRD |-> busy && !loadReady) else $error("accepting during poll");
  a_power_wait: assert property (@(posedge clk_sys) disable iff (srst)
    state == S_POWER |-> pins.chipSelN) else $error("access during power wait");
endmodule

// ### test/flash_dev_model.sv
`timescale 1ns/10ps
module flash_dev_model #(
  parameter int LOCK_NS = 500
) (
  input wire flash_host_pkg::pin_ctl_t pins,
  input wire logic [7:0] dataOut,
  input wire logic slow,
  output logic [7:0] dataIn
);
  logic [7:0] mem [0:65535];
  logic [7:0] lbuf [0:127];
  logic [127:0] lmask = '0;
  logic [15:0] aL;
  logic [7:0] dL, rdv;
  logic busyDev = 0;
  logic tog = 0;
  int seq = 0;
  realtime tF, tR;
  realtime tBad = -1.0e9;
  // Identification and chip erase not modelled; the host never issues them
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
  always @(negedge pins.writeStrobeN) if (!pins.chipSelN && pins.outGateN) begin
    aL = pins.addr;
    tF = $realtime;
  end
  always @(posedge pins.writeStrobeN) if (!pins.chipSelN && pins.outGateN && !busyDev
      && $realtime - tF > 15 && $realtime > LOCK_NS) begin
    dL = dataOut;
    tR = $realtime;
    // Protection never cleared, no power path here
    if (seq < 3) begin
      if ({aL, dL} == (seq == 1 ? {flash_host_pkg::UNLOCK_ADDR1, flash_host_pkg::UNLOCK_DATA1} :
          {flash_host_pkg::UNLOCK_ADDR0, seq == 2 ? flash_host_pkg::UNLOCK_DATA2 : flash_host_pkg::UNLOCK_DATA0}))
        seq++;
      else begin
        seq = 0;
        tBad = $realtime;
      end
    end else begin
      lbuf[aL[6:0]] = dL;
      lmask[aL[6:0]] = 1'b1;
    end
  end
  // Coarse 1 us check; a late close only lengthens the cycle
  always #1000 if (seq == 3 && lmask != 0 && $realtime - tR > 150000) begin
    busyDev = 1;
    for (int i = 0; i < 128; i++) mem[{aL[15:7], 7'(i)}] = lmask[i] ? lbuf[i] : 8'hFF;
    #(slow ? 100000 : 3000) busyDev = 0;
    seq = 0;
    lmask = '0;
  end
  always @(negedge pins.outGateN) if (busyDev) tog = ~tog;
  assign rdv = (busyDev || lmask != 0 || $realtime - tBad < 3000.0) && pins.addr == aL ?
    {~dL[7], tog, dL[5:0]} : mem[pins.addr];
  // Released bus shows the inverse, never a held value
  assign dataIn = !pins.chipSelN && !pins.outGateN && pins.writeStrobeN ? rdv : ~rdv;
endmodule

// ### test/parallel_sector_flash_program_tb_top.sv
`timescale 1ns/10ps
module parallel_sector_flash_program_tb_top;
  localparam int CYC = 3000;
  logic clk_sys = 0, srst = 1, readReq = 0, progReq = 0, loadValid = 0, slow = 0;
  logic [15:0] readAddr = '0;
  logic [8:0] progSector = '0, sec;
  logic [6:0] loadOffset = '0;
  logic [7:0] loadData = '0, readData, dataOut, dataIn, got;
  logic [7:0] eb [0:127];
  logic [127:0] em;
  logic loadReady, busy, readValid, timeoutErr, dataOe;
  flash_host_pkg::pin_ctl_t pins;
  int miscompares = 0, samples_checked = 0, seed = 32'hebec;
  initial forever #25 clk_sys = ~clk_sys;
  flash_host #(.POWERUP_CYCLES(20), .CYCLE_CYCLES(CYC)) i_flash_host (.clk_sys(clk_sys), .srst(srst),
    .readReq(readReq), .readAddr(readAddr), .progReq(progReq), .progSector(progSector), .loadReady(loadReady),
    .loadValid(loadValid), .loadOffset(loadOffset), .loadData(loadData), .loadLast(1'b0), .busy(busy),
    .readValid(readValid), .readData(readData), .timeoutErr(timeoutErr), .pins(pins), .dataOut(dataOut),
    .dataOe(dataOe), .dataIn(dataIn));
  flash_dev_model i_flash_dev_model (.pins(pins), .dataOut(dataOut), .slow(slow), .dataIn(dataIn));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic idle();
    int k = 0;
    while (busy !== 1'b0 && k < 9000) begin step(); k++; end
    if (k >= 9000) chk("idle", 8'h00, 8'h01);
  endtask
  task automatic rd(input logic [15:0] a);
    int k = 0;
    idle();
    readReq = 1;
    readAddr = a;
    step();
    readReq = 0;
    while (readValid !== 1'b1 && k < 20) begin step(); k++; end
    got = readData;
  endtask
  function automatic logic [7:0] expv(input int o);
    return em[o] ? eb[o] : 8'hFF;
  endfunction
  // Offsets 7F then 00 first, the rest random, so order is never sequential
  task automatic prog(input int n, input bit keep);
    int k;
    idle();
    if (!keep) sec = 9'($random(seed));
    em = '0;
    progReq = 1;
    progSector = sec;
    step();
    progReq = 0;
    loadValid = 1;
    for (int i = 0; i < n; i++) begin
      loadOffset = i == 0 ? 7'h7F : i == 1 ? 7'h00 : 7'($random(seed));
      loadData = 8'($random(seed));
      eb[loadOffset] = loadData;
      em[loadOffset] = 1'b1;
      k = 0;
      while (loadReady !== 1'b1 && k < 100) begin step(); k++; end
      step();
    end
    loadValid = 0;
    idle();
    chk("timeout flag", {7'h00, slow}, {7'h00, timeoutErr});
  endtask
  task automatic verify();
    for (int o = 0; o < 128; o++) begin
      rd({sec, 7'(o)});
      chk("sector byte", expv(o), got);
    end
  endtask
  always @(negedge clk_sys) if (dataOe === 1'b1 && pins.outGateN !== 1'b1) chk("bus clash", 8'h01, 8'h00);
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 srst = 0;
    chk("idle pins", 8'h07, {4'h0, dataOe, pins.chipSelN, pins.outGateN, pins.writeStrobeN});
    idle();
    rd(16'h1234);
    chk("erased byte", 8'hFF, got);
    prog(6, 0);
    verify();
    prog(3, 1);
    verify();
    slow = 1;
    prog(2, 0);
    // Device outlives the host poll limit; let it finish
    repeat (1000) step();
    slow = 0;
    verify();
    wrap_up();
  end
  initial begin
    #3000000;
    miscompares++;
    wrap_up();
  end
endmodule
